/* File: design/mab_pkg.sv */
// Overview of operation
// RULE1 - Address in first state, data afterwards
// RULE2 - Lowest address bit low for low-byte moves
// RULE3 - Multiplexed lines are active high
// RULE4 - Float low lines in acknowledge and hold
// RULE5 - Top four address bits in memory T1
// RULE6 - Upper lines low in I/O address state
// RULE7 - Status on upper lines, top bit low
// RULE8 - Interrupt-enable status refreshed every clock
// RULE9 - Segment code on two lowest status bits
// RULE10 - Float upper lines during hold or grant
// RULE11 - Byte devices qualify selects with low bit
// RULE12 - External latch captures address in T1
package mab_pkg;

	localparam int unsigned MAB_AD_W = 16;
	localparam int unsigned MAB_AS_W = 4;
	localparam int unsigned MAB_ADDR_W = 20;

	localparam logic [1:0] MAB_SEG_ALT = 2'h0;
	localparam logic [1:0] MAB_SEG_STACK = 2'h1;
	localparam logic [1:0] MAB_SEG_CODE = 2'h2;
	localparam logic [1:0] MAB_SEG_DATA = 2'h3;

	localparam logic [15:0] MAB_AD_RST = 16'h0000;
	localparam logic [3:0] MAB_AS_RST = 4'h0;
	localparam logic [3:0] MAB_AS_IO_ADDR = 4'h0;
	localparam logic MAB_TOP_STATUS = 1'b0;

	typedef enum logic [6:0] {
		MAB_ST_IDLE = 7'b0000001,
		MAB_ST_T1 = 7'b0000010,
		MAB_ST_T2 = 7'b0000100,
		MAB_ST_T3 = 7'b0001000,
		MAB_ST_TW = 7'b0010000,
		MAB_ST_T4 = 7'b0100000,
		MAB_ST_HOLD = 7'b1000000
	} mab_state_t;

	typedef struct packed {
		logic [19:0] addr;
		logic io;
		logic inta;
		logic wr;
		logic byte_lo;
		logic [1:0] seg;
		logic [15:0] wdata;
	} mab_req_t;

	localparam mab_req_t MAB_REQ_RST = '0;

endpackage

/* File: design/mab_pin_drv.sv */
`timescale 1ns/1ps
module mab_pin_drv #(
	parameter int unsigned W = 16
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic drive_i,
	input wire logic [W-1:0] value_i,
	output logic [W-1:0] pin_o,
	output logic pin_oe_o
);

	// Floating keeps the last driven level, like a weak bus keeper
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pin_o <= '0;
		end else if (drive_i) begin
			pin_o <= value_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pin_oe_o <= 1'b0;
		end else begin
			pin_oe_o <= drive_i;
		end
	end

endmodule // mab_pin_drv

/* File: design/mab_bus.sv */
`timescale 1ns/1ps
module mab_bus
	import mab_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic req_valid_i,
	input wire mab_req_t req_i,
	input wire logic ready_i,
	input wire logic int_enable_i,
	input wire logic hold_req_i,
	input wire logic [15:0] addr_data_lines_i,
	output logic [15:0] addr_data_lines_o,
	output logic addr_data_lines_oe_o,
	output logic [3:0] upper_addr_status_lines_o,
	output logic upper_addr_status_lines_oe_o,
	output logic req_ready_o,
	output logic done_o,
	output logic [15:0] rd_data_o,
	output logic hold_ack_o,
	output logic busy_o
);

	mab_state_t state_r;
	mab_state_t state_nxt;
	mab_req_t req_r;
	mab_req_t cur_req;
	logic take;
	logic ad_drive;
	logic [15:0] ad_value;
	logic as_drive;
	logic [3:0] as_value;
	logic [3:0] status_word;
	logic capture;

	assign take = req_valid_i & req_ready_o & ~hold_req_i;
	assign cur_req = take ? req_i : req_r;
	assign capture = ready_i & ((state_r == MAB_ST_T3) | (state_r == MAB_ST_TW));

	// Top bit fixed low, live interrupt flag, segment code
	assign status_word = {MAB_TOP_STATUS, int_enable_i, cur_req.seg}; // RULE7 RULE8 RULE9

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			MAB_ST_IDLE: begin
				if (hold_req_i) begin
					state_nxt = MAB_ST_HOLD;
				end else if (take) begin
					state_nxt = MAB_ST_T1;
				end
			end
			MAB_ST_T1: begin
				state_nxt = MAB_ST_T2; // RULE1
			end
			MAB_ST_T2: begin
				state_nxt = MAB_ST_T3;
			end
			MAB_ST_T3, MAB_ST_TW: begin
				// Slow devices stretch the cycle with wait states
				state_nxt = ready_i ? MAB_ST_T4 : MAB_ST_TW;
			end
			MAB_ST_T4: begin
				if (hold_req_i) begin
					state_nxt = MAB_ST_HOLD;
				end else if (take) begin
					state_nxt = MAB_ST_T1;
				end else begin
					state_nxt = MAB_ST_IDLE;
				end
			end
			MAB_ST_HOLD: begin
				if (!hold_req_i) begin
					state_nxt = MAB_ST_IDLE;
				end
			end
			default: begin
				state_nxt = MAB_ST_IDLE;
			end
		endcase
	end

	// Pin values are chosen from the next state so flops align with it
	always_comb begin
		ad_drive = 1'b0;
		ad_value = MAB_AD_RST;
		as_drive = 1'b1;
		as_value = status_word;
		case (state_nxt)
			MAB_ST_T1: begin
				// Address held only this state; latch must grab it now
				ad_drive = ~cur_req.inta; // RULE4 RULE12
				ad_value = {cur_req.addr[15:1], cur_req.addr[0] & ~cur_req.byte_lo}; // RULE1 RULE2
				if (cur_req.io | cur_req.inta) begin
					as_value = MAB_AS_IO_ADDR; // RULE6
				end else begin
					as_value = cur_req.addr[19:16]; // RULE5
				end
			end
			MAB_ST_T2, MAB_ST_T3, MAB_ST_TW, MAB_ST_T4: begin
				ad_drive = cur_req.wr & ~cur_req.inta; // RULE1 RULE4
				ad_value = cur_req.wdata; // RULE3
			end
			MAB_ST_HOLD: begin
				as_drive = 1'b0; // RULE10 RULE4
			end
			default: begin
				ad_drive = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_r <= MAB_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			req_r <= MAB_REQ_RST;
		end else if (take) begin
			req_r <= req_i;
		end
	end

	// Only idle or the last state may hand over to a new cycle
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			req_ready_o <= 1'b0;
		end else begin
			req_ready_o <= (state_nxt == MAB_ST_IDLE) | (state_nxt == MAB_ST_T4);
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rd_data_o <= MAB_AD_RST;
		end else if (capture & ~req_r.wr) begin
			rd_data_o <= addr_data_lines_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			done_o <= 1'b0;
		end else begin
			done_o <= capture;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			hold_ack_o <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			hold_ack_o <= (state_nxt == MAB_ST_HOLD);
			busy_o <= (state_nxt != MAB_ST_IDLE) & (state_nxt != MAB_ST_HOLD);
		end
	end

	mab_pin_drv #(
		.W(MAB_AD_W)
	) u_ad_drv (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.drive_i(ad_drive),
		.value_i(ad_value),
		.pin_o(addr_data_lines_o),
		.pin_oe_o(addr_data_lines_oe_o)
	);

	mab_pin_drv #(
		.W(MAB_AS_W)
	) u_as_drv (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.drive_i(as_drive),
		.value_i(as_value),
		.pin_o(upper_addr_status_lines_o),
		.pin_oe_o(upper_addr_status_lines_oe_o)
	);

endmodule // mab_bus

/* File: sim/mab_bus_sva.sv */
`timescale 1ns/1ps
module mab_bus_sva
	import mab_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic req_valid_i,
	input wire logic int_enable_i,
	input wire logic hold_req_i,
	input wire logic done_o,
	input wire logic hold_ack_o,
	input wire logic busy_o,
	input wire logic req_ready_o,
	input wire logic addr_data_lines_oe_o,
	input wire logic upper_addr_status_lines_oe_o,
	input wire mab_req_t req_i,
	input wire logic [15:0] addr_data_lines_o,
	input wire logic [3:0] upper_addr_status_lines_o
);
	wire t = req_valid_i & req_ready_o & !hold_req_i;
	wire mab_req_t r = req_i;
	wire [3:0] u = upper_addr_status_lines_o;
	wire [15:0] d = addr_data_lines_o;
	wire o = addr_data_lines_oe_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	chk_hi_addr:
	assert property (t & !r.io & !r.inta |=> u == $past(r.addr[19:16])) else $error("hi addr");
	chk_lo_addr:
	assert property (t & !r.inta |=> o & d == {$past(r.addr[15:1]), $past(r.addr[0]) & !$past(r.byte_lo)})
		else $error("lo addr");
	chk_io_low:
	assert property (t & (r.io | r.inta) |=> u == 4'h0) else $error("io addr");
	chk_status_bits:
	assert property (t |=> ##1 u == {1'b0, $past(int_enable_i), $past(r.seg, 2)}) else $error("status");
	chk_hold_float:
	assert property (hold_ack_o |-> !o & !upper_addr_status_lines_oe_o & $stable(u))
		else $error("hold");
	chk_done_time:
	assert property (t |=> !done_o [*3] ##[1:40] done_o) else $error("done");
	chk_inta_float:
	assert property (t & r.inta |=> !o [*4]) else $error("inta");
	chk_wr_data:
	assert property (t & r.wr & !r.inta |=> ##1 o & d == $past(r.wdata, 2)) else $error("wdata");
	chk_busy_span:
	assert property (t |=> busy_o [*4]) else $error("busy");
	cover property (t & r.wr);
	cover property (t & r.inta);
	cover property (hold_ack_o);
endmodule // mab_bus_sva
bind mab_bus mab_bus_sva chk (.*);

/* File: sim/mab_mem_model.sv */
`timescale 1ns/1ps
module mab_mem_model (
	input wire logic clk_i,
	input wire logic busy_i,
	input wire logic done_i,
	input wire logic slow_i,
	input wire logic oe_i,
	input wire logic [15:0] ad_i,
	output logic rdy_o,
	output logic [15:0] pin_o
);
	logic [15:0] addr_r, last_r;
	logic busy_r, done_r;
	always_ff @(posedge clk_i) begin
		busy_r <= busy_i;
		done_r <= done_i;
		last_r <= pin_o;
		if (busy_i & (!busy_r | done_r)) addr_r <= pin_o;
	end
	assign rdy_o = !slow_i;
	// Released lines give the latched address XOR 16'ha5c3 while busy and invert otherwise, so a stale level never passes
	assign pin_o = oe_i ? ad_i : busy_i ? addr_r ^ 16'ha5c3 : ~last_r;
endmodule // mab_mem_model

/* File: sim/mab_bus_tb.sv */
`timescale 1ns/1ps
module mab_bus_tb;
	import mab_pkg::*;
	logic clk_i = 0, sys_rst_i = 1, req_valid_i = 0, int_enable_i = 0, hold_req_i = 0;
	logic ready_i, addr_data_lines_oe_o, upper_addr_status_lines_oe_o, req_ready_o, done_o;
	logic hold_ack_o, busy_o;
	logic [15:0] addr_data_lines_i, addr_data_lines_o, rd_data_o;
	logic [3:0] upper_addr_status_lines_o;
	mab_req_t req_i = '0, r;
	logic [16:0] g = 17'h11da1, q[$];
	int bad_count = 0, compares = 0, n = 0;
	always #5 clk_i = !clk_i;
	mab_bus dut (.*);
	mab_mem_model mem (.clk_i, .busy_i(busy_o), .done_i(done_o), .slow_i(g[3] & g[7]),
		.oe_i(addr_data_lines_oe_o), .ad_i(addr_data_lines_o), .rdy_o(ready_i),
		.pin_o(addr_data_lines_i));
	function automatic logic [16:0] lfsr(input logic [16:0] v);
		return {v[15:0], v[16] ^ v[13]};
	endfunction
	task automatic check(input string w, input logic [15:0] s, x);
		compares++;
		if (s !== x) bad_count++;
		if (s !== x) $display("wrong value %s exp %h got %h", w, x, s);
	endtask
	task automatic conclude;
		$display("%0d compares %0d bad", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		g <= lfsr(g);
		int_enable_i <= g[0];
		n++;
		if (done_o) begin
			if (q[0][16]) check("rd_data", rd_data_o, q[0][15:0]);
			void'(q.pop_front());
		end
		if (n > 2000) begin
			bad_count++;
			conclude;
		end
	end
	initial begin
		repeat (16) @(posedge clk_i);
		sys_rst_i <= 0;
		repeat (2) @(posedge clk_i);
		for (int i = 0; i < 24; i++) begin
			// Random pool is wider than the request; top bits dropped on purpose
			r = 42'({g, lfsr(g), g[10:0]});
			r.seg = i[1:0];
			r.inta = i % 6 == 5;
			r.wr &= !r.inta;
			req_i <= r;
			req_valid_i <= 1;
			do @(posedge clk_i); while (!req_ready_o);
			r.addr[0] &= !r.byte_lo;
			q.push_back({!r.wr & !r.inta, r.addr[15:0] ^ 16'ha5c3});
		end
		req_valid_i <= 0;
		while (q.size() > 0) @(posedge clk_i);
		$display("bus cycles done");
		hold_req_i <= 1;
		repeat (3) @(posedge clk_i);
		check("hold_ack", 16'(hold_ack_o), 16'h1);
		check("hold_oe", 16'(addr_data_lines_oe_o | upper_addr_status_lines_oe_o), 16'h0);
		hold_req_i <= 0;
		repeat (2) @(posedge clk_i);
		check("release_oe", 16'(upper_addr_status_lines_oe_o), 16'h1);
		$display("hold done");
		conclude;
	end
endmodule // mab_bus_tb
